// *** rtl/multichannel_serial_port.sv ***
// multichannel serial port: double-buffered full-duplex serial link
// assumes pins are async to CLK and are synchronised here; bit clock <= CLK/2
`timescale 1ns/10ps
`include "serial_port_consts.svh"
module multichannel_serial_port
#(
  parameter int MAX_WORD = 32
)
(
  input wire logic CLK,
  input wire logic ARST_N,
  input wire serial_port_pkg::dir_cfg_t TX_CFG,
  input wire serial_port_pkg::dir_cfg_t RX_CFG,
  input wire serial_port_pkg::gen_cfg_t GEN_CFG,
  input wire logic ENABLE,
  input wire logic [31:0] TX_WRITE_DATA,
  input wire logic TX_WRITE,
  output logic [31:0] RX_READ_DATA,
  input wire logic RX_READ,
  output logic TX_READY,
  output logic RX_READY,
  output logic TX_EVENT,
  output logic RX_EVENT,
  output logic RX_OVERRUN,
  input wire logic TX_BIT_CLOCK_IN,
  output logic TX_BIT_CLOCK_OUT,
  output logic TX_BIT_CLOCK_OE,
  input wire logic TX_FRAME_SYNC_IN,
  output logic TX_FRAME_SYNC_OUT,
  output logic TX_FRAME_SYNC_OE,
  output logic TX_SERIAL_DATA,
  output logic TX_SERIAL_DATA_OE,
  input wire logic RX_BIT_CLOCK_IN,
  output logic RX_BIT_CLOCK_OUT,
  output logic RX_BIT_CLOCK_OE,
  input wire logic RX_FRAME_SYNC_IN,
  output logic RX_FRAME_SYNC_OUT,
  output logic RX_FRAME_SYNC_OE,
  input wire logic RX_SERIAL_DATA
);
  import serial_port_pkg::*;

  initial
  begin
    if (MAX_WORD != 32)
      $error("MAX_WORD must be 32");
  end

  // ==========================================================================
  // helpers
  function automatic logic [5:0] word_bits(input logic [2:0] code);
    unique case (code)
      `WLEN_8: word_bits = 6'h08;
      `WLEN_12: word_bits = 6'h0C;
      `WLEN_16: word_bits = 6'h10;
      `WLEN_20: word_bits = 6'h14;
      `WLEN_24: word_bits = 6'h18;
      default: word_bits = 6'h20;
    endcase
  endfunction

  function automatic logic [7:0] compress(input logic [15:0] lin, input logic law_a);
    logic sgn;
    logic [13:0] mag;
    logic [2:0] seg;
    logic [3:0] man;
    sgn = lin[15];
    mag = sgn ? 14'(~lin[15:2]) : lin[15:2];
    seg = 3'h0;
    man = 4'h0;
    if (!law_a)
    begin
      mag = (mag > 14'h1FDF) ? 14'h1FDF : mag;
      mag = 14'(mag + (`MU_BIAS >> 2));
      for (int i = 0; i < 8; i++)
        if (mag[i + 5])
          seg = 3'(i);
      man = 4'(mag >> (seg + 3'h1));
      compress = {sgn, seg, man} ^ `MU_LAW_XOR;
    end
    else
    begin
      mag = mag >> 1;
      for (int i = 0; i < 7; i++)
        if (mag[i + 5])
          seg = 3'(i + 1);
      man = (seg == 3'h0) ? mag[4:1] : 4'(mag >> seg);
      compress = {~sgn, seg, man} ^ `A_LAW_XOR;
    end
  endfunction

  function automatic logic [15:0] expand(input logic [7:0] code, input logic law_a);
    logic [7:0] c;
    logic [2:0] seg;
    logic [15:0] mag;
    c = law_a ? (code ^ `A_LAW_XOR) : (code ^ `MU_LAW_XOR);
    seg = c[6:4];
    if (!law_a)
      mag = 16'((({12'h000, c[3:0]} << 3) + 16'h0084) << seg) - 16'h0084;
    else if (seg == 3'h0)
      mag = {7'h00, c[3:0], 5'h10} >> 1;
    else
      mag = 16'({11'h001, c[3:0], 1'b1} << (seg + 3'h2));
    expand = (law_a ? !c[7] : c[7]) ? 16'(-mag) : mag;
  endfunction

  // ==========================================================================
  // state
  typedef enum logic [2:0] {IDLE = 3'b001, WAIT_SYNC = 3'b010, SHIFT = 3'b100} dir_state_t;

  typedef struct packed {
    sync_t sy;
    logic [7:0] div_cnt;
    logic gen_clk;
    logic [11:0] frame_cnt;
    logic gen_fs;
    logic tx_clk_d;
    logic rx_clk_d;
    logic tx_fs_d;
    logic rx_fs_d;
    dir_state_t tx_st;
    dir_state_t rx_st;
    logic [1:0] tx_dly;
    logic [1:0] rx_dly;
    logic [31:0] hold;
    logic hold_full;
    logic [31:0] tx_sh;
    logic [5:0] tx_bits;
    logic [6:0] tx_chan;
    logic tx_en_chan;
    logic [31:0] rx_sh;
    logic [5:0] rx_bits;
    logic [6:0] rx_chan;
    logic [31:0] buf_w;
    logic buf_full;
    logic [31:0] rd;
    logic rd_full;
    logic txd;
    logic txd_oe;
    logic tx_ev;
    logic rx_ev;
    logic ovr;
  } state_t;

  state_t s_r, s_nxt;

  logic [5:0] tx_len, rx_len;
  logic gen_rise, gen_fall;
  logic tx_c, rx_c, tx_f, rx_f;
  logic tx_out_edge, rx_smp_edge, tx_fs_start, rx_fs_start;
  logic [31:0] tx_load, rx_word;
  logic [7:0] en_cnt_tx;
  logic buf_take;

  always_comb
  begin
    s_nxt = s_r;
    s_nxt.tx_ev = 1'b0;
    s_nxt.rx_ev = 1'b0;
    tx_len = GEN_CFG.clock_stop ? word_bits(TX_CFG.word_len) : word_bits(TX_CFG.word_len);
    rx_len = word_bits(RX_CFG.word_len);
    en_cnt_tx = 8'h00;
    buf_take = 1'b0;
    // pins pass two flops before any use
    s_nxt.sy.tx_clk = {s_r.sy.tx_clk[0], TX_BIT_CLOCK_IN};
    s_nxt.sy.tx_fs = {s_r.sy.tx_fs[0], TX_FRAME_SYNC_IN};
    s_nxt.sy.rx_clk = {s_r.sy.rx_clk[0], RX_BIT_CLOCK_IN};
    s_nxt.sy.rx_fs = {s_r.sy.rx_fs[0], RX_FRAME_SYNC_IN};
    s_nxt.sy.rx_dat = {s_r.sy.rx_dat[0], RX_SERIAL_DATA};
    // ========================================================================
    // internal clock and frame generation, divide at least four
    gen_rise = 1'b0;
    gen_fall = 1'b0;
    if (ENABLE)
    begin
      if (s_r.div_cnt == 8'h00)
      begin
        s_nxt.div_cnt = (GEN_CFG.clk_div_m1 == 8'h00) ? 8'h01 : GEN_CFG.clk_div_m1;
        s_nxt.gen_clk = !s_r.gen_clk;
        gen_rise = !s_r.gen_clk;
        gen_fall = s_r.gen_clk;
      end
      else
        s_nxt.div_cnt = 8'(s_r.div_cnt - 8'h01);
      if (gen_fall)
      begin
        s_nxt.frame_cnt = (s_r.frame_cnt == GEN_CFG.frame_period_m1) ? 12'h000
          : 12'(s_r.frame_cnt + 12'h001);
        s_nxt.gen_fs = (s_nxt.frame_cnt <= {4'h0, GEN_CFG.fs_width_m1});
      end
    end
    // ========================================================================
    // choose clock and sync, apply polarity; generated ones are active high
    tx_c = TX_CFG.clk_internal ? s_r.gen_clk : (s_r.sy.tx_clk[1] ^ TX_CFG.clk_pol);
    rx_c = RX_CFG.clk_internal ? s_r.gen_clk : (s_r.sy.rx_clk[1] ^ RX_CFG.clk_pol);
    tx_f = TX_CFG.fs_internal ? s_r.gen_fs : (s_r.sy.tx_fs[1] ^ TX_CFG.fs_pol);
    rx_f = RX_CFG.fs_internal ? s_r.gen_fs : (s_r.sy.rx_fs[1] ^ RX_CFG.fs_pol);
    if (GEN_CFG.clock_stop)
    begin
      rx_c = tx_c;
      rx_f = tx_f;
    end
    s_nxt.tx_clk_d = tx_c;
    s_nxt.rx_clk_d = rx_c;
    tx_out_edge = tx_c && !s_r.tx_clk_d;
    rx_smp_edge = !rx_c && s_r.rx_clk_d;
    tx_fs_start = tx_out_edge && tx_f;
    rx_fs_start = rx_smp_edge && rx_f;
    if (tx_out_edge)
      s_nxt.tx_fs_d = tx_f;
    if (rx_smp_edge)
      s_nxt.rx_fs_d = rx_f;
    // ========================================================================
    // transmit
    if (TX_WRITE && !s_r.hold_full)
    begin
      s_nxt.hold = TX_WRITE_DATA;
      s_nxt.hold_full = 1'b1;
    end
    tx_load = (TX_CFG.compand_en) ? {s_r.hold[7:0], 24'h000000} : s_r.hold << (6'h20 - tx_len);
    if (TX_CFG.compand_en)
      tx_load = {compress(s_r.hold[15:0], TX_CFG.law_a), 24'h000000};
    for (int i = 0; i < 128; i++)
      if (TX_CFG.channel_enable[i])
        en_cnt_tx = 8'(en_cnt_tx + 8'h01);
    unique case (s_r.tx_st)
      IDLE:
        if (ENABLE && tx_fs_start && !(tx_f && s_r.tx_fs_d))
        begin
          s_nxt.tx_st = (GEN_CFG.fs_delay == 2'h0) ? SHIFT : WAIT_SYNC;
          s_nxt.tx_dly = GEN_CFG.fs_delay;
          s_nxt.tx_chan = 7'h00;
        end
      WAIT_SYNC:
        if (tx_out_edge)
        begin
          s_nxt.tx_dly = 2'(s_r.tx_dly - 2'h1);
          if (s_r.tx_dly == 2'h1)
            s_nxt.tx_st = SHIFT;
        end
      default: ;
    endcase
    if ((s_r.tx_st != SHIFT) && (s_nxt.tx_st == SHIFT))
    begin
      s_nxt.tx_bits = tx_len;
      s_nxt.tx_en_chan = !TX_CFG.multichannel || TX_CFG.channel_enable[0];
      s_nxt.tx_sh = tx_load;
      // only a full holder empties; a write in this cycle stays for the next word
      if (s_nxt.tx_en_chan && s_r.hold_full)
      begin
        s_nxt.hold_full = 1'b0;
        s_nxt.tx_ev = 1'b1;
      end
    end
    if ((s_r.tx_st == SHIFT) && tx_out_edge)
    begin
      s_nxt.txd = s_r.tx_sh[31];
      s_nxt.txd_oe = s_r.tx_en_chan;
      s_nxt.tx_sh = {s_r.tx_sh[30:0], 1'b0};
      s_nxt.tx_bits = 6'(s_r.tx_bits - 6'h01);
      if (s_r.tx_bits == 6'h01)
      begin
        s_nxt.tx_chan = 7'(s_r.tx_chan + 7'h01);
        if (GEN_CFG.clock_stop || !TX_CFG.multichannel
            || (s_r.tx_chan == TX_CFG.channels_per_frame_m1))
          s_nxt.tx_st = IDLE;
        else
        begin
          s_nxt.tx_bits = tx_len;
          s_nxt.tx_en_chan = TX_CFG.channel_enable[s_nxt.tx_chan];
          s_nxt.tx_sh = tx_load;
          if (s_nxt.tx_en_chan && s_r.hold_full)
          begin
            s_nxt.hold_full = 1'b0;
            s_nxt.tx_ev = 1'b1;
          end
        end
      end
    end
    if (s_r.tx_st == IDLE && tx_out_edge)
      s_nxt.txd_oe = 1'b0;
    // ========================================================================
    // receive
    unique case (s_r.rx_st)
      IDLE:
        if (ENABLE && rx_fs_start && !s_r.rx_fs_d)
        begin
          s_nxt.rx_st = (GEN_CFG.fs_delay == 2'h0) ? SHIFT : WAIT_SYNC;
          s_nxt.rx_dly = GEN_CFG.fs_delay;
          s_nxt.rx_chan = 7'h00;
          s_nxt.rx_bits = rx_len;
        end
      WAIT_SYNC:
        if (rx_smp_edge)
        begin
          s_nxt.rx_dly = 2'(s_r.rx_dly - 2'h1);
          if (s_r.rx_dly == 2'h1)
            s_nxt.rx_st = SHIFT;
        end
      default: ;
    endcase
    rx_word = s_r.rx_sh;
    if ((s_r.rx_st == SHIFT) && rx_smp_edge)
    begin
      s_nxt.rx_sh = {s_r.rx_sh[30:0], s_r.sy.rx_dat[1]};
      s_nxt.rx_bits = 6'(s_r.rx_bits - 6'h01);
      if (s_r.rx_bits == 6'h01)
      begin
        rx_word = s_nxt.rx_sh & (32'hFFFFFFFF >> (6'h20 - rx_len));
        if (RX_CFG.compand_en)
          rx_word = {{16{1'b0}}, expand(s_nxt.rx_sh[7:0], RX_CFG.law_a)};
        if (!RX_CFG.multichannel || RX_CFG.channel_enable[s_r.rx_chan])
        begin
          if (s_r.buf_full && s_r.rd_full)
            s_nxt.ovr = 1'b1;
          else
          begin
            s_nxt.buf_w = rx_word;
            s_nxt.buf_full = 1'b1;
            buf_take = 1'b1;
          end
        end
        s_nxt.rx_bits = rx_len;
        s_nxt.rx_chan = 7'(s_r.rx_chan + 7'h01);
        if (GEN_CFG.clock_stop || !RX_CFG.multichannel
            || (s_r.rx_chan == RX_CFG.channels_per_frame_m1))
          s_nxt.rx_st = IDLE;
      end
    end
    if (RX_READ && s_r.rd_full)
      s_nxt.rd_full = 1'b0;
    if (s_r.buf_full && !s_r.rd_full)
    begin
      s_nxt.rd = s_r.buf_w;
      s_nxt.rd_full = 1'b1;
      s_nxt.buf_full = buf_take;
      s_nxt.rx_ev = 1'b1;
    end
    if (!ENABLE)
    begin
      s_nxt.tx_st = IDLE;
      s_nxt.rx_st = IDLE;
      s_nxt.txd_oe = 1'b0;
    end
  end

  always_ff @(posedge CLK or negedge ARST_N)
  begin
    if (!ARST_N)
    begin
      s_r <= '0;
      s_r.tx_st <= IDLE;
      s_r.rx_st <= IDLE;
    end
    else
      s_r <= s_nxt;
  end

  // ==========================================================================
  // outputs, from flops except the clock and sync pin enables, which come from the configuration
  assign RX_READ_DATA = s_r.rd;
  assign TX_READY = !s_r.hold_full;
  assign RX_READY = s_r.rd_full;
  assign TX_EVENT = s_r.tx_ev;
  assign RX_EVENT = s_r.rx_ev;
  assign RX_OVERRUN = s_r.ovr;
  assign TX_BIT_CLOCK_OUT = s_r.tx_clk_d;
  assign TX_BIT_CLOCK_OE = TX_CFG.clk_internal;
  assign TX_FRAME_SYNC_OUT = s_r.gen_fs;
  assign TX_FRAME_SYNC_OE = TX_CFG.fs_internal;
  assign TX_SERIAL_DATA = s_r.txd;
  assign TX_SERIAL_DATA_OE = s_r.txd_oe;
  assign RX_BIT_CLOCK_OUT = s_r.rx_clk_d;
  assign RX_BIT_CLOCK_OE = RX_CFG.clk_internal && !GEN_CFG.clock_stop;
  assign RX_FRAME_SYNC_OUT = s_r.gen_fs;
  assign RX_FRAME_SYNC_OE = RX_CFG.fs_internal && !GEN_CFG.clock_stop;
endmodule

// *** rtl/serial_port_consts.svh ***
// constants for the multichannel serial port: channel limits, word length and law codes, companding, timing
// assumes inclusion by the port module only
`ifndef SERIAL_PORT_CONSTS_SVH
`define SERIAL_PORT_CONSTS_SVH
`define CLK_PERIOD_NS 8
`define MIN_BIT_CLOCK_DIVIDE 2
`define SYNC_STAGES 2
`define MAX_CHANNELS 128
`define MAX_ENABLED_CHANNELS 32
`define WLEN_8 3'h0
`define WLEN_12 3'h1
`define WLEN_16 3'h2
`define WLEN_20 3'h3
`define WLEN_24 3'h4
`define WLEN_32 3'h5
`define LAW_MU 1'h0
`define LAW_A 1'h1
`define MU_BIAS 14'h0084
`define A_LAW_XOR 8'h55
`define MU_LAW_XOR 8'hFF
`endif

// *** rtl/serial_port_pkg.sv ***
// types of the multichannel serial port
// assumes serial_port_consts.svh is on the include path
package serial_port_pkg;
  typedef struct packed {
    logic [2:0] word_len;
    logic compand_en;
    logic law_a;
    logic multichannel;
    logic [6:0] channels_per_frame_m1;
    logic [127:0] channel_enable;
    logic clk_internal;
    logic fs_internal;
    logic clk_pol;
    logic fs_pol;
  } dir_cfg_t;
  typedef struct packed {
    logic [7:0] clk_div_m1;
    logic [11:0] frame_period_m1;
    logic [7:0] fs_width_m1;
    logic [1:0] fs_delay;
    logic clock_stop;
    logic spi_master;
  } gen_cfg_t;
  typedef struct packed {
    logic [1:0] tx_clk;
    logic [1:0] tx_fs;
    logic [1:0] rx_clk;
    logic [1:0] rx_fs;
    logic [1:0] rx_dat;
  } sync_t;
endpackage

// *** tb/codec_model.sv ***
// codec model on the serial side: makes both bit clocks and syncs, sends and captures words
// assumes data changes on rising and is sampled on falling bit-clock edges, sync active high
`timescale 1ns/10ps
module codec_model
#(
  parameter int HALF_NS = 40
)
(
  output logic tx_clk,
  output logic tx_fs,
  output logic rx_clk,
  output logic rx_fs,
  output logic rx_dat,
  input wire logic tx_dat,
  input wire logic tx_dat_oe
);
  initial
  begin
    tx_clk = 1'b0;
    rx_clk = 1'b0;
    tx_fs = 1'b0;
    rx_fs = 1'b0;
    rx_dat = 1'b0;
  end
  // ==========================================================
  // one frame: one word each way at once, clocks stand still outside
  task automatic frame(input logic [31:0] rxw, input int n, output logic [31:0] txw);
    txw = 32'h0;
    for (int i = n; i >= 0; i--)
    begin
      #(HALF_NS);
      tx_clk = 1'b1;
      rx_clk = 1'b1;
      tx_fs = (i == n);
      rx_fs = (i == n);
      // the sync period carries no bit: the port shifts from the next edge on
      if (i < n)
        rx_dat = rxw[i];
      #(HALF_NS);
      tx_clk = 1'b0;
      rx_clk = 1'b0;
      if (i < n)
        txw = {txw[30:0], tx_dat_oe ? tx_dat : 1'bx};
    end
    #(HALF_NS);
    // released line shows the inverse of the last bit
    rx_dat = ~rx_dat;
    #(4 * HALF_NS);
  endtask
endmodule

// *** tb/multichannel_serial_port_tb.sv ***
// testbench of the multichannel serial port, word traffic through a codec model
// assumes the codec model makes all bit clocks and frame syncs; 125 MHz core clock
`timescale 1ns/10ps
module multichannel_serial_port_tb;
  import serial_port_pkg::*;
  logic clk, arst_n, enable, tx_write, rx_read;
  logic [31:0] tx_wdata;
  logic [31:0] rx_rdata;
  dir_cfg_t tx_cfg, rx_cfg;
  gen_cfg_t gen_cfg;
  logic tx_ready, rx_ready, rx_overrun, tx_bclk, tx_fs, rx_bclk, rx_fs, rx_dat, tx_dat, tx_oe;
  int bad_count;
  int samples_checked;
  int lens [6] = '{8, 12, 16, 20, 24, 32};
  multichannel_serial_port dut (.CLK(clk), .ARST_N(arst_n), .TX_CFG(tx_cfg), .RX_CFG(rx_cfg),
    .GEN_CFG(gen_cfg), .ENABLE(enable), .TX_WRITE_DATA(tx_wdata), .TX_WRITE(tx_write),
    .RX_READ_DATA(rx_rdata), .RX_READ(rx_read), .TX_READY(tx_ready), .RX_READY(rx_ready),
    .TX_EVENT(), .RX_EVENT(), .RX_OVERRUN(rx_overrun), .TX_BIT_CLOCK_IN(tx_bclk),
    .TX_BIT_CLOCK_OUT(), .TX_BIT_CLOCK_OE(), .TX_FRAME_SYNC_IN(tx_fs), .TX_FRAME_SYNC_OUT(),
    .TX_FRAME_SYNC_OE(), .TX_SERIAL_DATA(tx_dat), .TX_SERIAL_DATA_OE(tx_oe),
    .RX_BIT_CLOCK_IN(rx_bclk), .RX_BIT_CLOCK_OUT(), .RX_BIT_CLOCK_OE(),
    .RX_FRAME_SYNC_IN(rx_fs), .RX_FRAME_SYNC_OUT(), .RX_FRAME_SYNC_OE(),
    .RX_SERIAL_DATA(rx_dat));
  codec_model partner (.tx_clk(tx_bclk), .tx_fs(tx_fs), .rx_clk(rx_bclk), .rx_fs(rx_fs),
    .rx_dat(rx_dat), .tx_dat(tx_dat), .tx_dat_oe(tx_oe));
  initial
  begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  // ==========================================================
  // shared tasks
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [31:0] w);
    int n;
    n = 0;
    @(negedge clk);
    while (tx_ready !== 1'b1 && n < 3000)
    begin
      @(negedge clk);
      n++;
    end
    @(posedge clk);
    tx_wdata <= w;
    tx_write <= 1'b1;
    @(posedge clk);
    tx_write <= 1'b0;
  endtask
  task automatic rd(output logic [31:0] d);
    int n;
    n = 0;
    @(negedge clk);
    while (rx_ready !== 1'b1 && n < 3000)
    begin
      @(negedge clk);
      n++;
    end
    d = rx_rdata;
    @(posedge clk);
    rx_read <= 1'b1;
    @(posedge clk);
    rx_read <= 1'b0;
  endtask
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  // ==========================================================
  // scenarios
  task automatic t_reset();
    @(negedge clk);
    chk(32'(tx_ready), 32'h1);
    chk(32'(rx_ready), 32'h0);
    chk(32'(rx_overrun), 32'h0);
    $display("test reset done");
  endtask
  task automatic t_lengths();
    logic [31:0] w, v, m, got;
    for (int c = 0; c < 6; c++)
    begin
      w = 32'hA5C396E1 ^ 32'(c);
      v = 32'h5A3CE18F + 32'(c);
      m = 32'hFFFFFFFF >> (32 - lens[c]);
      @(posedge clk);
      tx_cfg.word_len <= 3'(c);
      rx_cfg.word_len <= 3'(c);
      wr(w);
      @(negedge clk);
      chk(32'(tx_ready), 32'h0);
      partner.frame(v, lens[c], got);
      chk(got, w & m);
      chk(32'(tx_ready), 32'h1);
      rd(got);
      chk(got, v & m);
    end
    $display("test lengths done");
  endtask
  task automatic t_double();
    logic [31:0] got;
    @(posedge clk);
    tx_cfg.word_len <= 3'h0;
    rx_cfg.word_len <= 3'h0;
    wr(32'h5A);
    @(negedge clk);
    fork
      partner.frame(32'h11, 8, got);
      wr(32'hC3);
    join
    chk(got, 32'h5A);
    partner.frame(32'h22, 8, got);
    chk(got, 32'hC3);
    partner.frame(32'h33, 8, got);
    chk(32'(rx_overrun), 32'h1);
    rd(got);
    chk(got, 32'h11);
    rd(got);
    chk(got, 32'h22);
    @(negedge clk);
    @(negedge clk);
    chk(32'(rx_ready), 32'h0);
    $display("test double buffer done");
  endtask
  task automatic t_compand();
    logic [31:0] got;
    @(posedge clk);
    tx_cfg.compand_en <= 1'b1;
    tx_cfg.law_a <= 1'b0;
    rx_cfg.compand_en <= 1'b1;
    rx_cfg.law_a <= 1'b1;
    wr(32'h1000);
    partner.frame(32'hD5, 8, got);
    chk(got, 32'hAF);
    rd(got);
    chk(got, 32'h8);
    @(posedge clk);
    tx_cfg.compand_en <= 1'b0;
    rx_cfg.compand_en <= 1'b0;
    $display("test compand done");
  endtask
  initial
  begin
    #200000;
    chk(32'h0, 32'h1);
    report_and_stop();
  end
  initial
  begin
    bad_count = 0;
    samples_checked = 0;
    arst_n = 1'b0;
    enable = 1'b0;
    tx_write = 1'b0;
    rx_read = 1'b0;
    tx_wdata = 32'h0;
    tx_cfg = '0;
    tx_cfg.channel_enable = '1;
    rx_cfg = tx_cfg;
    gen_cfg = '0;
    gen_cfg.clk_div_m1 = 8'h07;
    repeat (6) @(posedge clk);
    arst_n <= 1'b1;
    enable <= 1'b1;
    t_reset();
    t_lengths();
    t_double();
    t_compand();
    report_and_stop();
  end
endmodule

// *** tb/serial_port_props.sv ***
// checker for the multichannel serial port: handshake, flag and event relations
// assumes binding to multichannel_serial_port; one clock, asynchronous low reset
`timescale 1ns/10ps
module serial_port_props
#(
  parameter int MAX_WORD = 32
)
(
  input wire logic CLK,
  input wire logic ARST_N,
  input wire serial_port_pkg::dir_cfg_t TX_CFG,
  input wire logic TX_WRITE,
  input wire logic RX_READ,
  input wire logic [31:0] RX_READ_DATA,
  input wire logic TX_READY,
  input wire logic RX_READY,
  input wire logic TX_EVENT,
  input wire logic RX_EVENT,
  input wire logic RX_OVERRUN,
  input wire logic TX_BIT_CLOCK_OE
);
  import serial_port_pkg::*;
  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (!ARST_N);
  // ==========================================================
  // handshake steps
  sequence s_write_taken;
    TX_WRITE && TX_READY;
  endsequence
  sequence s_word_waiting;
    RX_READY && !RX_READ;
  endsequence
  a_write_fills_holder: assert property (s_write_taken |=> !TX_READY)
    else $error("holder empty after accepted write");
  a_tx_event_ready: assert property (TX_EVENT |-> TX_READY)
    else $error("tx event without ready");
  a_tx_ready_cause: assert property ($rose(TX_READY) |-> TX_EVENT)
    else $error("tx ready rose without event");
  a_rx_event_ready: assert property (RX_EVENT |-> RX_READY)
    else $error("rx event without ready");
  a_rx_ready_cause: assert property ($rose(RX_READY) |-> RX_EVENT)
    else $error("rx ready rose without event");
  a_tx_event_single: assert property (TX_EVENT |=> !TX_EVENT)
    else $error("tx event longer than one cycle");
  a_rx_event_single: assert property (RX_EVENT |=> !RX_EVENT)
    else $error("rx event longer than one cycle");
  a_rx_word_kept: assert property (s_word_waiting |=> RX_READY && $stable(RX_READ_DATA))
    else $error("unread word lost");
  a_overrun_sticks: assert property (RX_OVERRUN |=> RX_OVERRUN)
    else $error("overrun flag dropped");
  a_clock_pin_drive: assert property (TX_BIT_CLOCK_OE == TX_CFG.clk_internal)
    else $error("clock pin drive differs from source");
endmodule
bind multichannel_serial_port serial_port_props #(.MAX_WORD(MAX_WORD)) props (.CLK, .ARST_N,
  .TX_CFG, .TX_WRITE, .RX_READ, .RX_READ_DATA, .TX_READY, .RX_READY, .TX_EVENT, .RX_EVENT,
  .RX_OVERRUN, .TX_BIT_CLOCK_OE);
